// >>> hdl/sdf_cfg.svh
// sdf_cfg.svh: register map, field positions and counts for the sequencer.
// assumes it is included by the package and the design file.
`ifndef SDF_CFG_SVH
`define SDF_CFG_SVH
`define SDF_ADDR_MODE   4'h0
`define SDF_ADDR_STATUS 4'h4
`define SDF_ADDR_DATA   4'h8
`define SDF_ADDR_CHAN   4'hC
`define SDF_FS_MSB      9
`define SDF_FS_LSB      0
`define SDF_ZL_BIT      11
`define SDF_CHOP_BIT    12
`define SDF_DUAL_BIT    13
`define SDF_SEQ_BIT     14
`define SDF_THIRD_ORDER_SELECT_BIT   15
`define SDF_MODE_RST    32'h0000_0060
`define SDF_DEC_ZEROS   10'h000
`define SDF_FS_NOTCH    10'h060
`define SDF_FS_ONE      10'h001
`define SDF_N_THIRD_ORDER_SELECT     3'h3
`define SDF_N_SINC4     3'h4
`define SDF_N_ONE       3'h1
`define SDF_FIFO_DEPTH  16
`define SDF_DATA_W      24
`endif

// >>> hdl/sdf_pkg.sv
// sdf_pkg: types used by the filter sequencer; its result fifo stores sdf_res_t words as plain bits.
// assumes sdf_cfg.svh is on the include path.
`include "sdf_cfg.svh"
package sdf_pkg;
   typedef struct packed {
      logic       third_order_select;
      logic       seq;
      logic       dual;
      logic       chop;
      logic       zl;
      logic [9:0] fs;
   } sdf_mode_t;

   typedef struct packed {
      logic                      chopped;
      logic [`SDF_DATA_W-1:0]    data;
   } sdf_res_t;

   typedef enum logic [0:0] {SDF_SETTLE, SDF_RUN} sdf_state_t;
endpackage

// >>> hdl/sdf_seq.sv
// sdf_seq: conversion timing, chop sequencing and result buffering.
// assumes mclk_tick is a one-cycle pulse per master clock period and
// filt_data holds the decimator output, both synchronous to clk_sys.
// Notes on behaviour
// [RULE_01] writing mode bit 11 to one enables zero latency.
// [RULE_02] zero latency allows full settling before every result.
// [RULE_03] active channel sequencer forces zero latency.
// [RULE_04] third order zero latency: one result per 3*1024*fs ticks.
// [RULE_05] zero latency results come at one constant interval.
// [RULE_06] step on a conversion boundary yields only settled results.
// [RULE_07] step inside a conversion yields exactly one unsettled result.
// [RULE_08] dual-notch with fs of 96 puts notches at 50 and 60 Hz.
// [RULE_09] chop alternates normal and swapped polarity conversions.
// [RULE_10] chop averages each opposite-polarity pair into the result.
// [RULE_11] fourth order chop: one result per 4*1024*fs ticks.
// [RULE_12] chop accepts rate words from 1 to 1023.
// [RULE_13] chop settling lasts two output intervals.
// [RULE_14] channel switch resets filter, first result after full settling.
// [RULE_15] chop tracks a step after two conversions, three if mid-way.
// [RULE_16] host keeps chopped third order at or below 320 Hz.
// [RULE_17] third order filter chosen when its select bit is one.
// [RULE_18] plain mode: one result per 1024*fs ticks, fs 1 to 1023.
// [RULE_19] chop enable is a mode register control bit.
//
// Strobed register access and the register addresses were decided locally.

`include "sdf_cfg.svh"

////////////////////////////////////////////////////////////////////////////
module sdf_fifo #(
   parameter int WIDTH = 25,
   parameter int DEPTH = 16
) (
   input  wire logic             clk_sys,
   input  wire logic             reset_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic [$clog2(DEPTH):0] count
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wp;
   logic [AW-1:0]    rp;
   logic             push;
   logic             pop;

   assign in_ready  = (count != DEPTH[AW:0]);
   assign out_valid = (count != '0);
   assign out_data  = mem[rp];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wp] <= in_data;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         wp    <= '0;
         rp    <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wp <= wp + 1'b1;
         end
         if (pop) begin
            rp <= rp + 1'b1;
         end
         count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end
endmodule // sdf_fifo

////////////////////////////////////////////////////////////////////////////
module sdf_seq (
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   input  wire logic [3:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr_stb,
   input  wire logic        rd_stb,
   output logic [31:0]      rdata,
   input  wire logic        mclk_tick,
   input  wire logic [23:0] filt_data,
   output logic             filter_reset,
   output logic             chop_swap,
   output logic             notch_dual,
   output logic             third_order
);
   localparam int FW = `SDF_DATA_W + 1;

   sdf_pkg::sdf_mode_t  mode;
   sdf_pkg::sdf_state_t state;
   sdf_pkg::sdf_res_t   res;
   sdf_pkg::sdf_res_t   head;
   logic [3:0]  chan;
   logic [19:0] cnt;
   logic [19:0] ivl_len;
   logic [2:0]  pcnt;
   logic [2:0]  order;
   logic [2:0]  conv_len;
   logic [9:0]  fs_eff;
   logic        eff_zl;
   logic        ivl_end;
   logic        conv_end;
   logic        restart;
   logic        push;
   logic        fifo_ready;
   logic        fifo_valid;
   logic        pop;
   logic [4:0]  fifo_count;
   logic [23:0] prev;
   logic signed [24:0] diff;

   function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
      return a == r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // mode decode
   assign eff_zl   = mode.zl | mode.seq; // RULE_03
   assign order    = mode.third_order_select ? `SDF_N_THIRD_ORDER_SELECT : `SDF_N_SINC4; // RULE_17
   // a zero rate word would wrap the interval to 1048576 ticks, so it acts as one
   assign fs_eff   = (mode.fs == '0) ? `SDF_FS_ONE : mode.fs; // RULE_12
   assign ivl_len  = {fs_eff, `SDF_DEC_ZEROS}; // RULE_18

   // zero latency and chop run whole filter lengths per result
   always_comb begin
      if (mode.chop || eff_zl) begin
         conv_len = order; // RULE_02 RULE_04 RULE_11
      end else if (state == sdf_pkg::SDF_SETTLE) begin
         conv_len = order; // RULE_14
      end else begin
         conv_len = `SDF_N_ONE; // RULE_18
      end
   end

   assign restart = wr_stb &
                    (hit(addr, `SDF_ADDR_MODE) | hit(addr, `SDF_ADDR_CHAN));
   // a full fifo holds the engine; no result is ever dropped
   assign ivl_end  = mclk_tick & fifo_ready & (cnt == ivl_len - 20'h00001);
   assign conv_end = ivl_end & (pcnt == conv_len - `SDF_N_ONE); // RULE_05
   // the first chopped conversion only primes the pair
   assign push = conv_end &
                 !(mode.chop && state == sdf_pkg::SDF_SETTLE); // RULE_13
   assign diff = chop_swap ?
                 ($signed({prev[23], prev}) -
                  $signed({filt_data[23], filt_data})) :
                 ($signed({filt_data[23], filt_data}) -
                  $signed({prev[23], prev}));

   always_comb begin
      res.chopped = mode.chop;
      if (mode.chop) begin
         res.data = diff[24:1]; // RULE_10 RULE_15
      end else begin
         res.data = filt_data; // RULE_06 RULE_07
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register file
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         mode <= sdf_pkg::sdf_mode_t'(15'(`SDF_MODE_RST));
         chan <= 4'h0;
      end else if (wr_stb) begin
         if (hit(addr, `SDF_ADDR_MODE)) begin
            mode.fs    <= wdata[`SDF_FS_MSB:`SDF_FS_LSB];
            mode.zl    <= wdata[`SDF_ZL_BIT]; // RULE_01
            mode.chop  <= wdata[`SDF_CHOP_BIT]; // RULE_19
            mode.dual  <= wdata[`SDF_DUAL_BIT];
            mode.seq   <= wdata[`SDF_SEQ_BIT];
            mode.third_order_select <= wdata[`SDF_THIRD_ORDER_SELECT_BIT];
         end
         if (hit(addr, `SDF_ADDR_CHAN)) begin
            chan <= wdata[3:0];
         end
      end
   end

   assign pop = rd_stb & hit(addr, `SDF_ADDR_DATA) & fifo_valid;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rdata <= 32'h0000_0000;
      end else if (rd_stb) begin
         case (addr)
            `SDF_ADDR_MODE: begin
               rdata <= {16'h0000, mode.third_order_select, mode.seq, mode.dual,
                         mode.chop, mode.zl, 1'b0, mode.fs};
            end
            `SDF_ADDR_STATUS: begin
               rdata <= {24'h00_0000, fifo_count, state, chop_swap, eff_zl};
            end
            `SDF_ADDR_DATA: begin
               rdata <= fifo_valid ? {7'h00, head} : 32'h0000_0000;
            end
            `SDF_ADDR_CHAN: begin
               rdata <= {28'h000_0000, chan};
            end
            default: begin
               rdata <= 32'h0000_0000;
            end
         endcase
      end else begin
         rdata <= 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // conversion timing
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cnt  <= 20'h00000;
         pcnt <= 3'h0;
      end else if (restart) begin
         cnt  <= 20'h00000;
         pcnt <= 3'h0;
      end else if (mclk_tick && fifo_ready) begin
         if (ivl_end) begin
            cnt  <= 20'h00000;
            pcnt <= conv_end ? 3'h0 : pcnt + 3'h1;
         end else begin
            cnt <= cnt + 20'h00001;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state <= sdf_pkg::SDF_SETTLE;
      end else if (restart) begin
         state <= sdf_pkg::SDF_SETTLE; // RULE_14
      end else if (conv_end) begin
         state <= sdf_pkg::SDF_RUN;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         filter_reset <= 1'b0;
      end else begin
         filter_reset <= restart; // RULE_14
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // chop polarity and pairing
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         chop_swap <= 1'b0;
         prev      <= 24'h00_0000;
      end else if (restart) begin
         chop_swap <= 1'b0;
      end else if (conv_end && mode.chop) begin
         chop_swap <= ~chop_swap; // RULE_09
         prev      <= filt_data;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         notch_dual  <= 1'b0;
         third_order <= 1'b0;
      end else begin
         notch_dual  <= mode.dual & (mode.fs == `SDF_FS_NOTCH); // RULE_08
         third_order <= mode.third_order_select; // RULE_17
      end
   end

   sdf_fifo #(
      .WIDTH (FW),
      .DEPTH (`SDF_FIFO_DEPTH)
   ) u_fifo (
      .clk_sys   (clk_sys),
      .reset_n   (reset_n),
      .in_valid  (push),
      .in_ready  (fifo_ready),
      .in_data   (res),
      .out_valid (fifo_valid),
      .out_ready (pop),
      .out_data  (head),
      .count     (fifo_count)
   );

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   a_zl_bit_take: assert property ( // RULE_01
      wr_stb && addr == `SDF_ADDR_MODE && wdata[`SDF_ZL_BIT] |=> eff_zl)
      else $error("zero latency bit not taken");
   a_seq_forces: assert property ( // RULE_03
      mode.seq |-> eff_zl && conv_len != `SDF_N_ONE)
      else $error("sequencer did not force zero latency");
   a_zl_length: assert property ( // RULE_04
      eff_zl && !mode.chop && mode.third_order_select |-> conv_len == `SDF_N_THIRD_ORDER_SELECT)
      else $error("zero latency third order length wrong");
   a_chop_length: assert property ( // RULE_11
      mode.chop && !mode.third_order_select |-> conv_len == `SDF_N_SINC4)
      else $error("chop fourth order length wrong");
   a_plain_length: assert property ( // RULE_18
      !eff_zl && !mode.chop && state == sdf_pkg::SDF_RUN
      |-> conv_len == `SDF_N_ONE)
      else $error("plain mode length wrong");
   a_chop_toggle: assert property ( // RULE_09
      conv_end && mode.chop && !restart |=> chop_swap != $past(chop_swap))
      else $error("chop polarity did not swap");
   // the priming conversion adds nothing; a read in that cycle may still pop
   a_chop_prime: assert property ( // RULE_13
      conv_end && mode.chop && state == sdf_pkg::SDF_SETTLE
      |=> fifo_count <= $past(fifo_count))
      else $error("chop result before two conversions");
   a_push_boundary: assert property ( // RULE_05
      push |-> ivl_end && pcnt == conv_len - `SDF_N_ONE)
      else $error("result off the conversion boundary");
   a_dual_notch: assert property ( // RULE_08
      mode.dual && mode.fs == `SDF_FS_NOTCH |=> notch_dual)
      else $error("dual notch not selected");
   a_notch_clear: assert property ( // RULE_08
      !mode.dual || mode.fs != `SDF_FS_NOTCH |=> !notch_dual)
      else $error("dual notch set without its select");
   a_third_sel: assert property ( // RULE_17
      third_order == $past(mode.third_order_select))
      else $error("filter order select not followed");
   a_status_zl: assert property ( // RULE_03
      rd_stb && addr == `SDF_ADDR_STATUS |=> rdata[0] == $past(eff_zl))
      else $error("status does not show effective zero latency");
   a_rate_nonzero: assert property ( // RULE_12
      ivl_len >= {`SDF_FS_ONE, `SDF_DEC_ZEROS})
      else $error("rate word below one");
   // a full fifo must freeze the tick counter, else a result would be lost
   a_fifo_hold: assert property ( // RULE_05
      mclk_tick && !fifo_ready && !restart |=> cnt == $past(cnt))
      else $error("tick counter ran with the fifo full");
   a_reset_pulse: assert property ( // RULE_14
      restart |=> filter_reset && state == sdf_pkg::SDF_SETTLE &&
                  cnt == 20'h00000)
      else $error("channel switch did not reset filter");
   a_reset_cause: assert property ( // RULE_14
      filter_reset |-> $past(restart))
      else $error("filter reset without a switch");
endmodule // sdf_seq

// >>> dv/sdf_mod_model.sv
// sdf_mod_model: stand-in for the modulator and decimator ahead of sdf_seq.
// assumes gap >= 1; one mclk_tick every gap cycles of clk_sys.
module sdf_mod_model (
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   input  wire logic [3:0]  gap,
   input  wire logic [23:0] lvl,
   input  wire logic [23:0] off,
   input  wire logic        chop_swap,
   output logic             mclk_tick,
   output logic [23:0]      filt_data,
   output logic [31:0]      ticks
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] div;

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         div <= 4'h0;
         mclk_tick <= 1'b0;
         ticks <= 32'h0000_0000;
      end else if (div + 4'h1 >= gap) begin
         div <= 4'h0;
         mclk_tick <= 1'b1;
         ticks <= ticks + 32'h0000_0001;
      end else begin
         div <= div + 4'h1;
         mclk_tick <= 1'b0;
      end
   end

   // swapping the inputs turns the signal round but not the front-end offset
   assign filt_data = chop_swap ? off - lvl : off + lvl;
endmodule // sdf_mod_model

// >>> dv/tb.sv
// tb: register-level checks of conversion timing, chop and result buffer.
// assumes rate word 1, so one conversion interval is 1024 ticks.
`include "sdf_cfg.svh"
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int L = 1024;
   localparam logic [31:0] F1 = 32'h0000_0001;
   localparam logic [31:0] ZL = 32'h1 << `SDF_ZL_BIT;
   localparam logic [31:0] CH = 32'h1 << `SDF_CHOP_BIT;
   localparam logic [31:0] DU = 32'h1 << `SDF_DUAL_BIT;
   localparam logic [31:0] SQ = 32'h1 << `SDF_SEQ_BIT;
   localparam logic [31:0] S3 = 32'h1 << `SDF_THIRD_ORDER_SELECT_BIT;
   logic        clk_sys, reset_n, wr_stb, rd_stb, mclk_tick, fr_seen;
   logic        filter_reset, chop_swap, notch_dual, third_order;
   logic [3:0]  addr, gap;
   logic [31:0] wdata, rdata, ticks, t0, d;
   logic [23:0] lvl, off, filt_data;
   logic [24:0] pl;
   int          n_fail, n_tests, i;

   sdf_seq dut (.clk_sys(clk_sys), .reset_n(reset_n), .addr(addr),
      .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
      .mclk_tick(mclk_tick), .filt_data(filt_data),
      .filter_reset(filter_reset), .chop_swap(chop_swap),
      .notch_dual(notch_dual), .third_order(third_order));
   sdf_mod_model u_mod (.clk_sys(clk_sys), .reset_n(reset_n), .gap(gap),
      .lvl(lvl), .off(off), .chop_swap(chop_swap), .mclk_tick(mclk_tick),
      .filt_data(filt_data), .ticks(ticks));

   ////////////////////////////////////////////////////////////////////////
   task close_out;
      $display("compares %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk_sys);
      addr <= a;
      wdata <= v;
      wr_stb <= 1'b1;
      @(posedge clk_sys);
      wr_stb <= 1'b0;
      #1 fr_seen = filter_reset;
   endtask

   task rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk_sys);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk_sys);
      rd_stb <= 1'b0;
      #1 v = rdata;
   endtask

   // bounded: a stalled tick source ends the run instead of hanging it
   task wait_to(input logic [31:0] t);
      int k;
      for (k = 0; k < 40000 && ticks < t; k++)
         @(posedge clk_sys);
      if (ticks < t) begin
         n_fail++;
         $display("[ERR] t=%0t got %h exp %h", $time, ticks, t);
         close_out;
      end
   endtask

   task cnt_is(input logic [31:0] n);
      logic [31:0] v;
      rd(`SDF_ADDR_STATUS, v);
      chk({27'h0000000, v[7:3]}, n);
   endtask

   // an empty fifo reads 0 and pops nothing, so over-reading is harmless
   task drain;
      logic [31:0] v;
      for (int k = 0; k < 17; k++)
         rd(`SDF_ADDR_DATA, v);
   endtask

   task conv(input logic [3:0] a, input logic [31:0] m, input int first,
             input int nxt, input logic [24:0] exp);
      logic [31:0] v;
      wr(a, m);
      t0 = ticks;
      chk({31'h0, fr_seen}, 32'h1);
      drain;
      if (exp[24]) begin
         wait_to(t0 + 32'(first * L / 2 + 8));
         chk({31'h0, chop_swap}, 32'h1);
      end
      wait_to(t0 + 32'(first * L - 8));
      cnt_is(32'h0);
      wait_to(t0 + 32'(first * L + 8));
      cnt_is(32'h1);
      wait_to(t0 + 32'((first + nxt) * L - 8));
      cnt_is(32'h1);
      wait_to(t0 + 32'((first + nxt) * L + 8));
      cnt_is(32'h2);
      for (int k = 0; k < 2; k++) begin
         rd(`SDF_ADDR_DATA, v);
         chk(v, {7'h00, exp});
      end
      $display("test conv %h done", m);
   endtask

   task nd(input logic [31:0] m, input logic e);
      wr(`SDF_ADDR_MODE, m);
      @(posedge clk_sys);
      #1 chk({31'h0, notch_dual}, {31'h0, e});
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   initial begin
      reset_n = 1'b0;
      addr = 4'h0;
      wdata = 32'h0000_0000;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      gap = 4'h1;
      lvl = 24'h01_2340;
      off = 24'h00_0100;
      pl = {1'b0, lvl + off};
      n_fail = 0;
      n_tests = 0;
      repeat (12) @(posedge clk_sys);
      reset_n <= 1'b1;
      rd(`SDF_ADDR_MODE, d);
      chk(d, `SDF_MODE_RST);
      chk({29'h0, chop_swap, notch_dual, third_order}, 32'h0);
      rd(4'h2, d);
      chk(d, 32'h0);
      wr(4'h2, 32'hFFFF_FFFF);
      rd(`SDF_ADDR_MODE, d);
      chk(d, `SDF_MODE_RST);
      $display("test reset done");
      conv(`SDF_ADDR_MODE, F1, 4, 1, pl);
      chk({31'h0, third_order}, 32'h0);
      conv(`SDF_ADDR_MODE, F1 | S3, 3, 1, pl);
      chk({31'h0, third_order}, 32'h1);
      gap <= 4'h2;
      conv(`SDF_ADDR_MODE, F1 | S3 | ZL, 3, 3, pl);
      rd(`SDF_ADDR_STATUS, d);
      chk({31'h0, d[0]}, 32'h1);
      gap <= 4'h1;
      conv(`SDF_ADDR_MODE, F1 | S3 | SQ, 3, 3, pl);
      rd(`SDF_ADDR_STATUS, d);
      chk({31'h0, d[0]}, 32'h1);
      // chop is tested with the fourth order only
      conv(`SDF_ADDR_MODE, F1 | CH, 8, 4, {1'b1, lvl});
      conv(`SDF_ADDR_CHAN, 32'h3, 8, 4, {1'b1, lvl});
      nd(DU | 32'h60, 1'b1);
      nd(DU | 32'h5F, 1'b0);
      nd(32'h60, 1'b0);
      wr(`SDF_ADDR_MODE, CH | 32'h3FF);
      rd(`SDF_ADDR_MODE, d);
      chk(d, CH | 32'h3FF);
      $display("test notch and range done");
      wr(`SDF_ADDR_MODE, F1);
      t0 = ticks;
      drain;
      wait_to(t0 + 32'(22 * L));
      cnt_is(32'h10);
      for (i = 0; i < 16; i++) begin
         rd(`SDF_ADDR_DATA, d);
         chk(d, {7'h00, pl});
      end
      cnt_is(32'h0);
      rd(`SDF_ADDR_DATA, d);
      chk(d, 32'h0);
      $display("test fifo done");
      close_out;
   end
endmodule // tb
